// file: src/scd_decode.sv
// Sanitize command parameter decoder with register port and pass sequencer.
// Assumes one master on the register port and a sanitize engine downstream.
`timescale 1ns/100ps
`include "scd_defines.svh"

module scd_decode (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Decoded command to the engine
	output logic start_o,
	output scd_pkg::scd_action_e action_o,
	output logic unrestricted_o,
	output logic invert_o,
	output scd_pkg::scd_pass_t pass_total_o,
	output logic [31:0] pattern_o,
	// Command result
	output logic abort_o,
	output logic [7:0] status_code_o,
	// Overwrite passes
	input wire logic pass_req_i,
	output logic [31:0] pass_pattern_o,
	output scd_pkg::scd_pass_t pass_index_o,
	output logic pass_valid_o,
	output logic pass_last_o,
	output logic busy_o
);

	// Action legal and enabled in the capability mask
	function automatic logic scd_action_ok(input logic [2:0] act, input logic [31:0] caps);
		logic ok;
		ok = 1'b0;
		unique case (act)
			scd_pkg::SCD_ACT_EXIT_FAIL,
			scd_pkg::SCD_ACT_BLOCK_ERASE,
			scd_pkg::SCD_ACT_OVERWRITE,
			scd_pkg::SCD_ACT_CRYPTO_ERASE: begin
				ok = caps[act];
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction : scd_action_ok

	logic [31:0] word0_reg;
	logic [31:0] word1_reg;
	logic [31:0] caps_reg;
	logic accepted_reg;
	logic aborted_reg;
	logic [7:0] code_reg;
	logic [2:0] last_act_reg;
	scd_pkg::scd_state_e state_reg;
	scd_pkg::scd_state_e state_next;

	logic wr_word0;
	logic wr_word1;
	logic wr_ctrl;
	logic wr_caps;
	logic submit;
	logic clear;
	logic cancel;
	logic go_ok;
	logic go_bad;
	logic [2:0] act;
	logic is_over;
	logic is_exit;
	logic [3:0] pass_field;
	scd_pkg::scd_pass_t pass_count;
	logic gen_valid;
	logic gen_last;
	logic gen_left;
	logic [31:0] gen_pat;
	scd_pkg::scd_pass_t gen_idx;
	logic load;
	logic [31:0] rd_mux;

	assign wr_word0 = wr_i && (addr_i == `SCD_OFF_CMD_WORD0);
	assign wr_word1 = wr_i && (addr_i == `SCD_OFF_CMD_WORD1);
	assign wr_ctrl = wr_i && (addr_i == `SCD_OFF_CTRL);
	assign wr_caps = wr_i && (addr_i == `SCD_OFF_CAPS);
	assign submit = wr_ctrl && wdata_i[`SCD_CTRL_SUBMIT];
	assign clear = wr_ctrl && wdata_i[`SCD_CTRL_CLEAR];
	assign cancel = wr_ctrl && wdata_i[`SCD_CTRL_CANCEL];

	assign act = word0_reg[`SCD_ACT_MSB:`SCD_ACT_LSB];
	assign is_over = act == scd_pkg::SCD_ACT_OVERWRITE;
	assign is_exit = act == scd_pkg::SCD_ACT_EXIT_FAIL;
	assign pass_field = word0_reg[`SCD_PASS_MSB:`SCD_PASS_LSB];

	assign pass_count = (pass_field == 4'h0) ? `SCD_PASS_ZERO_MEANS : {1'b0, pass_field};

	// A submit during a running overwrite is dropped, not queued
	// unsupported action aborted
	assign go_ok = submit && (state_reg == scd_pkg::SCD_ST_IDLE) && scd_action_ok(act, caps_reg);
	assign go_bad = submit && (state_reg == scd_pkg::SCD_ST_IDLE) && !scd_action_ok(act, caps_reg);
	assign load = go_ok && is_over;

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			word0_reg <= 32'h0;
		end else if (wr_word0) begin
			word0_reg <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			word1_reg <= 32'h0;
		end else if (wr_word1) begin
			word1_reg <= wdata_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			caps_reg <= `SCD_CAPS_RESET;
		end else if (wr_caps) begin
			caps_reg <= wdata_i & `SCD_CAPS_RESET;
		end
	end

	// Result flags: a new result beats a clear in the same write
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			accepted_reg <= 1'b0;
			aborted_reg <= 1'b0;
			code_reg <= `SCD_CODE_SUCCESS;
			last_act_reg <= 3'h0;
		end else if (go_ok || go_bad) begin
			accepted_reg <= go_ok;
			aborted_reg <= go_bad;
			code_reg <= go_ok ? `SCD_CODE_SUCCESS : `SCD_CODE_INVALID_FIELD;
			last_act_reg <= act;
		end else if (clear) begin
			accepted_reg <= 1'b0;
			aborted_reg <= 1'b0;
			code_reg <= `SCD_CODE_SUCCESS;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			start_o <= 1'b0;
			action_o <= scd_pkg::SCD_ACT_RSVD0;
			unrestricted_o <= 1'b0;
			invert_o <= 1'b0;
			pass_total_o <= 5'h0;
			pattern_o <= 32'h0;
		end else begin
			start_o <= go_ok;
			if (go_ok) begin
				action_o <= scd_pkg::scd_action_e'(act);
				unrestricted_o <= word0_reg[`SCD_UNRESTRICTED_BIT] && !is_exit;
				invert_o <= word0_reg[`SCD_INVERT_BIT] && is_over;
				pass_total_o <= is_over ? pass_count : 5'h0;
				pattern_o <= is_over ? word1_reg : 32'h0;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			abort_o <= 1'b0;
			status_code_o <= `SCD_CODE_SUCCESS;
		end else begin
			abort_o <= go_bad;
			if (go_ok || go_bad) begin
				status_code_o <= go_ok ? `SCD_CODE_SUCCESS : `SCD_CODE_INVALID_FIELD;
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			scd_pkg::SCD_ST_IDLE: begin
				if (load) begin
					state_next = scd_pkg::SCD_ST_RUN;
				end
			end
			scd_pkg::SCD_ST_RUN: begin
				if (cancel || (gen_valid && gen_last)) begin
					state_next = scd_pkg::SCD_ST_IDLE;
				end
			end
			default: begin
				state_next = scd_pkg::SCD_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_reg <= scd_pkg::SCD_ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	scd_pass_gen u_pass_gen (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.load_i(load),
		.pattern_i(word1_reg),
		.invert_i(word0_reg[`SCD_INVERT_BIT]),
		.total_i(pass_count),
		.req_i(pass_req_i && (state_reg == scd_pkg::SCD_ST_RUN) && !cancel),
		.pat_o(gen_pat),
		.idx_o(gen_idx),
		.valid_o(gen_valid),
		.last_o(gen_last),
		.left_o(gen_left)
	);

	// Registered again so every output leaves from this module's flops
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pass_pattern_o <= 32'h0;
			pass_index_o <= 5'h0;
			pass_valid_o <= 1'b0;
			pass_last_o <= 1'b0;
		end else begin
			pass_valid_o <= gen_valid;
			if (gen_valid) begin
				pass_pattern_o <= gen_pat;
				pass_index_o <= gen_idx;
				pass_last_o <= gen_last;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			busy_o <= 1'b0;
		end else begin
			busy_o <= state_next == scd_pkg::SCD_ST_RUN;
		end
	end

	always_comb begin
		rd_mux = 32'h0;
		unique case (addr_i)
			`SCD_OFF_CMD_WORD0: begin
				rd_mux = word0_reg;
			end
			`SCD_OFF_CMD_WORD1: begin
				rd_mux = word1_reg;
			end
			`SCD_OFF_STATUS: begin
				rd_mux[`SCD_STS_ACCEPTED] = accepted_reg;
				rd_mux[`SCD_STS_ABORTED] = aborted_reg;
				rd_mux[`SCD_STS_BUSY] = state_reg == scd_pkg::SCD_ST_RUN;
				rd_mux[`SCD_STS_CODE_MSB:`SCD_STS_CODE_LSB] = code_reg;
				rd_mux[`SCD_STS_ACT_MSB:`SCD_STS_ACT_LSB] = last_act_reg;
			end
			`SCD_OFF_CAPS: begin
				rd_mux = caps_reg;
			end
			`SCD_OFF_PASSES: begin
				rd_mux[4:0] = pass_count - {4'h0, gen_left};
			end
			default: begin
				rd_mux = 32'h0;
			end
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rdata_o <= 32'h0;
		end else if (rd_i) begin
			rdata_o <= rd_mux;
		end else begin
			rdata_o <= 32'h0;
		end
	end

endmodule : scd_decode

// file: src/scd_defines.svh
// Offsets, field positions, reset values and codes of the sanitize decoder.
// Assumes byte addresses on an 8-bit register port with 32-bit data.
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

// Register byte offsets
`define SCD_OFF_CMD_WORD0 8'h00
`define SCD_OFF_CMD_WORD1 8'h04
`define SCD_OFF_CTRL 8'h08
`define SCD_OFF_STATUS 8'h0c
`define SCD_OFF_CAPS 8'h10
`define SCD_OFF_PASSES 8'h14

// First command word fields
`define SCD_ACT_MSB 2
`define SCD_ACT_LSB 0
`define SCD_UNRESTRICTED_BIT 3
`define SCD_PASS_MSB 7
`define SCD_PASS_LSB 4
`define SCD_INVERT_BIT 8

// Control register bits
`define SCD_CTRL_SUBMIT 0
`define SCD_CTRL_CLEAR 1
`define SCD_CTRL_CANCEL 2

// Status register fields
`define SCD_STS_ACCEPTED 0
`define SCD_STS_ABORTED 1
`define SCD_STS_BUSY 2
`define SCD_STS_CODE_MSB 15
`define SCD_STS_CODE_LSB 8
`define SCD_STS_ACT_MSB 18
`define SCD_STS_ACT_LSB 16

// Reset values and codes
`define SCD_CAPS_RESET 32'h0000001e
`define SCD_PASS_ZERO_MEANS 5'h10
`define SCD_CODE_SUCCESS 8'h00
`define SCD_CODE_INVALID_FIELD 8'h02

`endif

// file: src/scd_pkg.sv
// Types shared by the sanitize decoder files.
// Assumes the constants header is included where numbers are needed.
package scd_pkg;

	typedef enum logic [2:0] {
		SCD_ACT_RSVD0 = 3'h0,
		SCD_ACT_EXIT_FAIL = 3'h1,
		SCD_ACT_BLOCK_ERASE = 3'h2,
		SCD_ACT_OVERWRITE = 3'h3,
		SCD_ACT_CRYPTO_ERASE = 3'h4
	} scd_action_e;

	typedef enum logic [1:0] {
		SCD_ST_IDLE = 2'h1,
		SCD_ST_RUN = 2'h2
	} scd_state_e;

	typedef logic [4:0] scd_pass_t;

endpackage : scd_pkg

// file: src/scd_pass_gen.sv
// Per-pass overwrite pattern source for the sanitize decoder.
// Assumes the requester pulses req_i once per pass wanted.
`timescale 1ns/100ps
`include "scd_defines.svh"

module scd_pass_gen (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Load from the decoder
	input wire logic load_i,
	input wire logic [31:0] pattern_i,
	input wire logic invert_i,
	input wire scd_pkg::scd_pass_t total_i,
	// Pass requests
	input wire logic req_i,
	output logic [31:0] pat_o,
	output scd_pkg::scd_pass_t idx_o,
	output logic valid_o,
	output logic last_o,
	output logic left_o
);

	logic [31:0] cur_reg;
	logic inv_reg;
	scd_pkg::scd_pass_t total_reg;
	scd_pkg::scd_pass_t idx_reg;
	logic take;

	// Requests past the final pass are dropped
	assign take = req_i && (idx_reg != total_reg);

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cur_reg <= 32'h0;
			inv_reg <= 1'b0;
			total_reg <= 5'h0;
			idx_reg <= 5'h0;
		end else if (load_i) begin
			cur_reg <= pattern_i;
			inv_reg <= invert_i;
			total_reg <= total_i;
			idx_reg <= 5'h0;
		end else if (take) begin
			idx_reg <= idx_reg + 5'h1;
			if (inv_reg) begin
				cur_reg <= ~cur_reg;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			pat_o <= 32'h0;
			idx_o <= 5'h0;
			valid_o <= 1'b0;
			last_o <= 1'b0;
		end else begin
			valid_o <= take && !load_i;
			if (take && !load_i) begin
				pat_o <= cur_reg;
				idx_o <= idx_reg;
				last_o <= (idx_reg + 5'h1) == total_reg;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			left_o <= 1'b0;
		end else if (load_i) begin
			left_o <= total_i != 5'h0;
		end else if (take) begin
			left_o <= (idx_reg + 5'h1) != total_reg;
		end
	end

endmodule : scd_pass_gen

// file: test/scd_decode_assertions.sv
// Checker on the decoder's decoded outputs.
// Assumes binding onto scd_decode.
`timescale 1ns/100ps
module scd_decode_checker (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// Watched outputs
	input wire logic start_o,
	input wire scd_pkg::scd_action_e action_o,
	input wire logic unrestricted_o,
	input wire logic invert_o,
	input wire scd_pkg::scd_pass_t pass_total_o,
	input wire logic [31:0] pattern_o,
	input wire logic abort_o,
	input wire logic [7:0] status_code_o,
	input wire logic [31:0] pass_pattern_o,
	input wire scd_pkg::scd_pass_t pass_index_o,
	input wire logic pass_valid_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	logic [31:0] prev_pat_reg;
	always_ff @(posedge mclk_i) begin
		if (pass_valid_o) begin
			prev_pat_reg <= pass_pattern_o;
		end
	end
	sequence s_inv_later;
		pass_valid_o && invert_o && pass_index_o != 5'h00;
	endsequence
	property p_act;
		start_o |-> action_o >= 3'h1 && action_o <= 3'h4 && status_code_o == 8'h00;
	endproperty
	property p_abort;
		abort_o |-> status_code_o == 8'h02 && !start_o;
	endproperty
	property p_inv;
		start_o && action_o != 3'h3 |-> !invert_o;
	endproperty
	property p_total;
		start_o |-> (action_o == 3'h3) == (pass_total_o != 5'h00);
	endproperty
	property p_unres;
		start_o && action_o == 3'h1 |-> !unrestricted_o;
	endproperty
	property p_pat;
		start_o && action_o != 3'h3 |-> pattern_o == 32'h0;
	endproperty
	property p_flip;
		s_inv_later |-> pass_pattern_o == ~prev_pat_reg;
	endproperty
	property p_keep;
		pass_valid_o && !invert_o |-> pass_pattern_o == pattern_o;
	endproperty
	property p_first;
		pass_valid_o && pass_index_o == 5'h00 |-> pass_pattern_o == pattern_o;
	endproperty
	a_act: assert property (p_act) else $error("bad action on start");
	a_abort: assert property (p_abort) else $error("bad abort code");
	a_inv: assert property (p_inv) else $error("invert not gated");
	a_total: assert property (p_total) else $error("pass total wrong");
	a_unres: assert property (p_unres) else $error("unrestricted not gated");
	a_pat: assert property (p_pat) else $error("pattern not gated");
	a_flip: assert property (p_flip) else $error("pattern not flipped");
	a_keep: assert property (p_keep) else $error("pattern changed");
	a_first: assert property (p_first) else $error("first pass pattern wrong");
endmodule : scd_decode_checker

bind scd_decode scd_decode_checker scd_decode_checker_inst (.mclk_i(mclk_i), .reset_i(reset_i),
	.start_o(start_o), .action_o(action_o), .unrestricted_o(unrestricted_o), .invert_o(invert_o),
	.pass_total_o(pass_total_o), .pattern_o(pattern_o), .abort_o(abort_o), .status_code_o(status_code_o),
	.pass_pattern_o(pass_pattern_o), .pass_index_o(pass_index_o), .pass_valid_o(pass_valid_o));

// file: test/scd_host_model.sv
// Host software model issuing register accesses.
// Assumes read data one cycle after the strobe.
`timescale 1ns/100ps
module scd_host_model (
	// Clock
	input wire logic mclk_i,
	// Register port
	output logic [7:0] addr_o,
	output logic [31:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [31:0] rdata_i
);
	initial begin
		addr_o = 8'h00;
		wdata_o = 32'h0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// Released lines show inverted junk, not stale values
	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge mclk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : wr32
	task automatic rd32(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rdata_i;
	endtask : rd32
endmodule : scd_host_model

// file: test/sanitize_command_decode_tb_top.sv
// Self-checking bench for the sanitize decoder.
// Assumes the host model drives the register port.
`timescale 1ns/100ps
`include "scd_defines.svh"
module sanitize_command_decode_tb_top;
	logic mclk_i, reset_i, wr, rd, pass_req;
	logic [7:0] addr, status_code;
	logic [31:0] wdata, rdata, pattern, pass_pattern;
	logic start, unrestricted, invert, abort, pass_valid, pass_last, busy;
	scd_pkg::scd_action_e action;
	scd_pkg::scd_pass_t pass_total, pass_index;
	int num_errors, samples_checked;
	scd_host_model scd_host_model_inst (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd), .rdata_i(rdata));
	scd_decode scd_decode_inst (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .start_o(start), .action_o(action),
		.unrestricted_o(unrestricted), .invert_o(invert), .pass_total_o(pass_total), .pattern_o(pattern),
		.abort_o(abort), .status_code_o(status_code), .pass_req_i(pass_req), .pass_pattern_o(pass_pattern),
		.pass_index_o(pass_index), .pass_valid_o(pass_valid), .pass_last_o(pass_last), .busy_o(busy));
	always #12.5 mclk_i = ~mclk_i;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	task automatic submit(input logic [31:0] w0, input logic [31:0] w1);
		scd_host_model_inst.wr32(`SCD_OFF_CMD_WORD0, w0);
		scd_host_model_inst.wr32(`SCD_OFF_CMD_WORD1, w1);
		scd_host_model_inst.wr32(`SCD_OFF_CTRL, 32'h1);
		// Result pulses stand only in the cycle after the submit edge
		#1;
	endtask : submit
	task automatic t_regs();
		logic [31:0] d;
		scd_host_model_inst.rd32(`SCD_OFF_CAPS, d);
		chk("caps", `SCD_CAPS_RESET, d);
		scd_host_model_inst.rd32(8'h20, d);
		chk("unmapped", 32'h0, d);
		// Overwrite made unsupported
		scd_host_model_inst.wr32(`SCD_OFF_CAPS, 32'hffff_fff6);
		submit(32'h13, 32'h0);
		chk("cap abort", 32'h1, {31'h0, abort});
		scd_host_model_inst.rd32(`SCD_OFF_STATUS, d);
		chk("status", 32'h0003_0202, d);
		scd_host_model_inst.wr32(`SCD_OFF_CTRL, 32'h2);
		scd_host_model_inst.rd32(`SCD_OFF_STATUS, d);
		chk("cleared", 32'h0003_0000, d);
		scd_host_model_inst.wr32(`SCD_OFF_CAPS, 32'h1e);
	endtask : t_regs
	task automatic t_actions();
		logic [2:0] c;
		logic ok;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			ok = c >= 3'h1 && c <= 3'h4;
			submit({24'h1, 4'h5, c[0], c}, 32'ha5c3_0f96);
			chk("start", {31'h0, ok}, {31'h0, start});
			chk("abort", {31'h0, !ok}, {31'h0, abort});
			if (ok) begin
				chk("action", {29'h0, c}, {29'h0, action});
				chk("unres", {31'h0, c[0] && c != 3'h1}, {31'h0, unrestricted});
				chk("invert", {31'h0, c == 3'h3}, {31'h0, invert});
				chk("total", c == 3'h3 ? 32'h5 : 32'h0, {27'h0, pass_total});
				chk("pattern", c == 3'h3 ? 32'ha5c3_0f96 : 32'h0, pattern);
			end else begin
				chk("code", 32'h2, {24'h0, status_code});
			end
			scd_host_model_inst.wr32(`SCD_OFF_CTRL, 32'h4);
		end
	endtask : t_actions
	task automatic t_passes(input logic inv);
		int k;
		k = 0;
		submit({23'h0, inv, 4'h3, 1'b0, 3'h3}, 32'h1234_00ff);
		chk("word", 32'h1234_00ff, pattern);
		chk("busy run", 32'h1, {31'h0, busy});
		@(posedge mclk_i);
		pass_req <= 1'b1;
		// Three back-to-back requests, bounded wait
		for (int n = 0; n < 8 && k < 3; n++) begin
			@(posedge mclk_i);
			if (n == 2) begin
				pass_req <= 1'b0;
			end
			#1;
			if (pass_valid === 1'b1) begin
				chk("idx", k, {27'h0, pass_index});
				chk("pass pat", inv && k[0] ? 32'hedcb_ff00 : 32'h1234_00ff, pass_pattern);
				chk("last", {31'h0, k == 2}, {31'h0, pass_last});
				k++;
			end
		end
		chk("passes", 32'h3, k);
		if (k != 3) begin
			wrap_up();
		end
		chk("busy", 32'h0, {31'h0, busy});
		// Request past the final pass
		@(posedge mclk_i);
		pass_req <= 1'b1;
		@(posedge mclk_i);
		pass_req <= 1'b0;
		@(posedge mclk_i);
		#1;
		chk("refused", 32'h0, {31'h0, pass_valid});
	endtask : t_passes
	initial begin
		mclk_i = 1'b0;
		reset_i = 1'b1;
		pass_req = 1'b0;
		num_errors = 0;
		samples_checked = 0;
		repeat (5) @(posedge mclk_i);
		reset_i <= 1'b0;
		t_regs();
		t_actions();
		t_passes(1'b0);
		t_passes(1'b1);
		wrap_up();
	end
endmodule : sanitize_command_decode_tb_top
